// ---- verilog/cbs_pkg.sv ----
package cbs_pkg;
	// configuration byte offsets
	localparam logic [7:0] OFS_CAP_PTR    = 8'h14;
	localparam logic [7:0] OFS_SEC_STATUS = 8'h16;
	localparam logic [7:0] OFS_PRI_BUS    = 8'h18;
	localparam logic [7:0] OFS_SEC_BUS    = 8'h19;
	localparam logic [7:0] OFS_SUB_BUS    = 8'h1a;
	localparam logic [7:0] OFS_PM_DW0     = 8'ha0;
	localparam logic [7:0] OFS_PM_DW1     = 8'ha4;

	// reset and fixed values
	localparam logic [7:0]  CAP_PTR_VALUE   = 8'ha0;
	localparam logic [7:0]  BUS_NUM_RESET   = 8'h00;
	localparam logic [1:0]  DEVSEL_MEDIUM   = 2'h1;
	localparam logic [15:0] STATUS_FIXED    = 16'h0200;

	// secondary status field positions
	localparam int STS_PARITY_DETECTED = 15;
	localparam int STS_SYSTEM_ERROR    = 14;
	localparam int STS_MASTER_ABORT_RX = 13;
	localparam int STS_TARGET_ABORT_RX = 12;
	localparam int STS_TARGET_ABORT_TX = 11;
	localparam int STS_DEVSEL_LSB      = 9;
	localparam int STS_DATA_PARITY     = 8;
	localparam logic [15:0] STS_STICKY_MASK = 16'hf900;

	// card bus clock limit
	localparam int CLK_SYS_HZ   = 40_000_000;
	localparam int CCLK_MAX_HZ  = 33_000_000;
	localparam int CCLK_DIV     = (CLK_SYS_HZ + CCLK_MAX_HZ - 1) / CCLK_MAX_HZ;
	localparam int CCLK_CNT_W   = 4;
endpackage : cbs_pkg

// ---- verilog/cbs_func_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbs_func_regs (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic        i_soft_rst,
	// configuration writes
	input  wire logic        i_wr_status_dw,
	input  wire logic        i_wr_bus_dw,
	input  wire logic [3:0]  i_be,
	input  wire logic [31:0] i_wdata,
	// error events, one cycle each
	input  wire logic [5:0]  i_evt,
	// register contents
	output logic      [15:0] o_status,
	output logic      [7:0]  o_pri_bus,
	output logic      [7:0]  o_sec_bus,
	output logic      [7:0]  o_sub_bus
);
	logic [15:0] clr_mask;
	logic [15:0] set_mask;

	// merge a written byte where its lane is enabled
	function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic en,
		input logic [7:0] new_v);
		merge_byte = en ? new_v : old_v;
	endfunction

	// write-one clear only on sticky bits, upper half of the dword
	always_comb begin
		clr_mask = 16'h0000;
		if (i_wr_status_dw) begin
			clr_mask[7:0]  = i_be[2] ? i_wdata[23:16] : 8'h00;
			clr_mask[15:8] = i_be[3] ? i_wdata[31:24] : 8'h00;
		end
		clr_mask = clr_mask & cbs_pkg::STS_STICKY_MASK;
		set_mask = {i_evt[5:1], 2'h0, i_evt[0], 8'h00};
	end

	// sticky flags: the async global reset or a write of one clears them, the function reset does not; set beats clear
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_status <= cbs_pkg::STATUS_FIXED;
		end else begin
			o_status <= ((o_status & ~clr_mask) | set_mask | cbs_pkg::STATUS_FIXED)
				& (cbs_pkg::STS_STICKY_MASK | cbs_pkg::STATUS_FIXED);
		end
	end

	// bus numbers: global and function reset both return them to zero
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pri_bus <= cbs_pkg::BUS_NUM_RESET;
			o_sec_bus <= cbs_pkg::BUS_NUM_RESET;
			o_sub_bus <= cbs_pkg::BUS_NUM_RESET;
		end else if (i_soft_rst) begin
			o_pri_bus <= cbs_pkg::BUS_NUM_RESET;
			o_sec_bus <= cbs_pkg::BUS_NUM_RESET;
			o_sub_bus <= cbs_pkg::BUS_NUM_RESET;
		end else if (i_wr_bus_dw) begin
			o_pri_bus <= merge_byte(o_pri_bus, i_be[0], i_wdata[7:0]);
			o_sec_bus <= merge_byte(o_sec_bus, i_be[1], i_wdata[15:8]);
			o_sub_bus <= merge_byte(o_sub_bus, i_be[2], i_wdata[23:16]);
		end
	end
endmodule // cbs_func_regs
`default_nettype wire

// ---- verilog/cbs_bridge_cfg.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbs_bridge_cfg #(
	parameter int NUM_FUNC = 2,
	parameter int FUNC_W   = 1
) (
	// clock and global reset
	input  wire logic                i_clk_sys,
	input  wire logic                i_rstn,
	// per-function soft reset, leaves error flags alone
	input  wire logic [NUM_FUNC-1:0] i_func_rst,
	// configuration access
	input  wire logic                i_cfg_req,
	input  wire logic                i_cfg_wr,
	input  wire logic [FUNC_W-1:0]   i_cfg_func,
	input  wire logic [5:0]          i_cfg_dword,
	input  wire logic [3:0]          i_cfg_be,
	input  wire logic [31:0]         i_cfg_wdata,
	output logic                     o_cfg_ack,
	output logic                     o_cfg_claim,
	output logic                     o_cfg_pm_hit,
	output logic      [31:0]         o_cfg_rdata,
	// card-side events from bridge logic, same clock
	input  wire logic [NUM_FUNC-1:0] i_cb_addr_par_err,
	input  wire logic [NUM_FUNC-1:0] i_cb_data_par_err,
	input  wire logic [NUM_FUNC-1:0] i_cb_master_abort,
	input  wire logic [NUM_FUNC-1:0] i_cb_target_abort_rx,
	input  wire logic [NUM_FUNC-1:0] i_cb_target_abort_tx,
	input  wire logic [NUM_FUNC-1:0] i_cb_master_dphase,
	input  wire logic [NUM_FUNC-1:0] i_parity_resp_en,
	// card pins, active low, asynchronous
	input  wire logic [NUM_FUNC-1:0] i_cb_cserr_n,
	input  wire logic [NUM_FUNC-1:0] i_cb_cperr_n,
	// card system-error pin drive
	output logic      [NUM_FUNC-1:0] o_cb_cserr_n_o,
	output logic      [NUM_FUNC-1:0] o_cb_cserr_n_oe,
	// card clock rate enable
	output logic                     o_cb_clk_en,
	// configuration forwarding decision
	input  wire logic                i_fwd_req,
	input  wire logic [FUNC_W-1:0]   i_fwd_func,
	input  wire logic [7:0]          i_fwd_bus,
	output logic                     o_fwd_valid,
	output logic                     o_fwd_type0,
	output logic                     o_fwd_type1
);
	localparam logic [5:0] DW_STATUS = 6'(cbs_pkg::OFS_CAP_PTR >> 2);
	localparam logic [5:0] DW_BUS    = 6'(cbs_pkg::OFS_PRI_BUS >> 2);
	localparam logic [5:0] DW_PM0    = 6'(cbs_pkg::OFS_PM_DW0 >> 2);
	localparam logic [5:0] DW_PM1    = 6'(cbs_pkg::OFS_PM_DW1 >> 2);

	// pin synchronisers, two stages each
	logic [NUM_FUNC-1:0] cserr_meta;
	logic [NUM_FUNC-1:0] cserr_sync;
	logic [NUM_FUNC-1:0] cperr_meta;
	logic [NUM_FUNC-1:0] cperr_sync;
	// qualifiers delayed to line up with the synchronised parity pin
	logic [NUM_FUNC-1:0] dphase_d1;
	logic [NUM_FUNC-1:0] dphase_d2;
	logic [NUM_FUNC-1:0] presp_d1;
	logic [NUM_FUNC-1:0] presp_d2;
	logic [NUM_FUNC-1:0] cserr_prev;

	// per-function contents
	logic [15:0] status  [NUM_FUNC];
	logic [7:0]  pri_bus [NUM_FUNC];
	logic [7:0]  sec_bus [NUM_FUNC];
	logic [7:0]  sub_bus [NUM_FUNC];

	logic                      hit_status;
	logic                      hit_bus;
	logic                      hit_pm;
	logic [31:0]               next_rdata;
	logic [cbs_pkg::CCLK_CNT_W-1:0] cclk_cnt;

	// decode of a config dword for the selected function
	function automatic logic dw_hit(input logic [5:0] dw, input logic [5:0] want);
		dw_hit = (dw == want);
	endfunction

	// asserted card pins seen through two flops
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cserr_meta <= '0;
			cserr_sync <= '0;
			cperr_meta <= '0;
			cperr_sync <= '0;
		end else begin
			cserr_meta <= ~i_cb_cserr_n;
			cserr_sync <= cserr_meta;
			cperr_meta <= ~i_cb_cperr_n;
			cperr_sync <= cperr_meta;
		end
	end

	// align mastering and parity enable with the pin delay
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			dphase_d1  <= '0;
			dphase_d2  <= '0;
			presp_d1   <= '0;
			presp_d2   <= '0;
			cserr_prev <= '0;
		end else begin
			dphase_d1  <= i_cb_master_dphase;
			dphase_d2  <= dphase_d1;
			presp_d1   <= i_parity_resp_en;
			presp_d2   <= presp_d1;
			cserr_prev <= cserr_sync;
		end
	end

	// dword decode
	always_comb begin
		hit_status = dw_hit(i_cfg_dword, DW_STATUS);
		hit_bus    = dw_hit(i_cfg_dword, DW_BUS);
		hit_pm     = dw_hit(i_cfg_dword, DW_PM0) | dw_hit(i_cfg_dword, DW_PM1);
	end

	// one register set per socket function
	genvar f;
	generate
		for (f = 0; f < NUM_FUNC; f++) begin : g_func
			logic       sel;
			logic [5:0] evt;
			always_comb begin
				sel = i_cfg_req & i_cfg_wr & (i_cfg_func == FUNC_W'(f));
				evt[5] = i_cb_addr_par_err[f] | i_cb_data_par_err[f];
				evt[4] = cserr_sync[f] & ~cserr_prev[f];
				evt[3] = i_cb_master_abort[f];
				evt[2] = i_cb_target_abort_rx[f];
				evt[1] = i_cb_target_abort_tx[f];
				evt[0] = cperr_sync[f] & dphase_d2[f] & presp_d2[f];
			end
			cbs_func_regs u_regs (
				.i_clk_sys      (i_clk_sys),
				.i_rstn         (i_rstn),
				.i_soft_rst     (i_func_rst[f]),
				.i_wr_status_dw (sel & hit_status),
				.i_wr_bus_dw    (sel & hit_bus),
				.i_be           (i_cfg_be),
				.i_wdata        (i_cfg_wdata),
				.i_evt          (evt),
				.o_status       (status[f]),
				.o_pri_bus      (pri_bus[f]),
				.o_sec_bus      (sec_bus[f]),
				.o_sub_bus      (sub_bus[f])
			);
		end
	endgenerate

	// read data for the addressed dword
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_status) begin
			// pointer is a constant per function; status high half
			next_rdata = {status[i_cfg_func], 8'h00, cbs_pkg::CAP_PTR_VALUE};
			next_rdata[cbs_pkg::STS_DEVSEL_LSB+17:cbs_pkg::STS_DEVSEL_LSB+16] =
				cbs_pkg::DEVSEL_MEDIUM;
			next_rdata[23:16] = 8'h00;
		end else if (hit_bus) begin
			next_rdata = {8'h00, sub_bus[i_cfg_func], sec_bus[i_cfg_func],
				pri_bus[i_cfg_func]};
		end
	end

	// access answer, one cycle after the request
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cfg_ack    <= 1'b0;
			o_cfg_claim  <= 1'b0;
			o_cfg_pm_hit <= 1'b0;
			o_cfg_rdata  <= 32'h0000_0000;
		end else begin
			o_cfg_ack    <= i_cfg_req;
			o_cfg_claim  <= i_cfg_req & (hit_status | hit_bus);
			o_cfg_pm_hit <= i_cfg_req & hit_pm;
			o_cfg_rdata  <= (i_cfg_req & ~i_cfg_wr) ? next_rdata : 32'h0000_0000;
		end
	end

	// system-error line is never driven by this end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cb_cserr_n_o  <= '1;
			o_cb_cserr_n_oe <= '0;
		end else begin
			o_cb_cserr_n_o  <= '1;
			o_cb_cserr_n_oe <= '0;
		end
	end

	// card clock enable, divided to stay at or under the limit
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cclk_cnt    <= '0;
			o_cb_clk_en <= 1'b0;
		end else if (cclk_cnt == cbs_pkg::CCLK_CNT_W'(cbs_pkg::CCLK_DIV - 1)) begin
			cclk_cnt    <= '0;
			o_cb_clk_en <= 1'b1;
		end else begin
			cclk_cnt    <= cclk_cnt + 1'b1;
			o_cb_clk_en <= 1'b0;
		end
	end

	// forwarding decision from secondary and subordinate numbers
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_fwd_valid <= 1'b0;
			o_fwd_type0 <= 1'b0;
			o_fwd_type1 <= 1'b0;
		end else begin
			o_fwd_valid <= i_fwd_req;
			o_fwd_type0 <= i_fwd_req & (i_fwd_bus == sec_bus[i_fwd_func]);
			o_fwd_type1 <= i_fwd_req & (i_fwd_bus > sec_bus[i_fwd_func])
				& (i_fwd_bus <= sub_bus[i_fwd_func]);
		end
	end
endmodule // cbs_bridge_cfg
`default_nettype wire

// ---- test/cbs_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbs_props #(
	parameter int NUM_FUNC = 2,
	parameter int FUNC_W   = 1
) (
	// clock, reset and requests
	input  wire logic                i_clk_sys,
	input  wire logic                i_rstn,
	input  wire logic                i_cfg_req,
	input  wire logic                i_cfg_wr,
	input  wire logic [FUNC_W-1:0]   i_cfg_func,
	input  wire logic [5:0]          i_cfg_dword,
	input  wire logic [NUM_FUNC-1:0] i_cb_addr_par_err,
	input  wire logic                i_fwd_req,
	// answers
	input  wire logic                o_cfg_ack,
	input  wire logic                o_cfg_claim,
	input  wire logic                o_cfg_pm_hit,
	input  wire logic [31:0]         o_cfg_rdata,
	input  wire logic [NUM_FUNC-1:0] o_cb_cserr_n_o,
	input  wire logic [NUM_FUNC-1:0] o_cb_cserr_n_oe,
	input  wire logic                o_cb_clk_en,
	input  wire logic                o_fwd_valid,
	input  wire logic                o_fwd_type0,
	input  wire logic                o_fwd_type1
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// status read of function 0
	sequence s_rd0;
		i_cfg_req && !i_cfg_wr && i_cfg_func == '0 && i_cfg_dword == 6'h05;
	endsequence
	AST_ACK: assert property (i_cfg_req |=> o_cfg_ack) else $error("no ack");
	AST_NO_ACK: assert property (!i_cfg_req |=> !o_cfg_ack) else $error("stray ack");
	AST_FIXED: assert property (s_rd0 |=> o_cfg_rdata[15:0] == 16'h00a0 &&
		o_cfg_rdata[26:25] == 2'h1 && o_cfg_rdata[23:16] == 8'h00) else $error("fixed bits");
	AST_PM: assert property (i_cfg_req && i_cfg_dword inside {6'h28, 6'h29}
		|=> o_cfg_pm_hit && !o_cfg_claim) else $error("pm hit");
	AST_UNMAP: assert property (i_cfg_req && !(i_cfg_dword inside {6'h05, 6'h06, 6'h28, 6'h29})
		|=> !o_cfg_claim && o_cfg_rdata == 32'h0) else $error("unmapped claim");
	AST_PAR: assert property (i_cb_addr_par_err[0] ##1 s_rd0 |=> o_cfg_rdata[31])
		else $error("parity flag");
	AST_CSERR: assert property (o_cb_cserr_n_oe == '0 && o_cb_cserr_n_o == '1)
		else $error("cserr driven");
	AST_CLK: assert property (o_cb_clk_en |=> !o_cb_clk_en) else $error("clk fast");
	AST_FWD: assert property (i_fwd_req |=> o_fwd_valid && !(o_fwd_type0 && o_fwd_type1))
		else $error("fwd answer");
	AST_FWD_IDLE: assert property (!i_fwd_req |=> !o_fwd_valid) else $error("stray fwd");
endmodule // cbs_props
bind cbs_bridge_cfg cbs_props #(.NUM_FUNC(NUM_FUNC), .FUNC_W(FUNC_W)) u_cbs_props (
	.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cfg_req(i_cfg_req), .i_cfg_wr(i_cfg_wr),
	.i_cfg_func(i_cfg_func), .i_cfg_dword(i_cfg_dword), .i_cb_addr_par_err(i_cb_addr_par_err),
	.i_fwd_req(i_fwd_req), .o_cfg_ack(o_cfg_ack), .o_cfg_claim(o_cfg_claim),
	.o_cfg_pm_hit(o_cfg_pm_hit), .o_cfg_rdata(o_cfg_rdata), .o_cb_cserr_n_o(o_cb_cserr_n_o),
	.o_cb_cserr_n_oe(o_cb_cserr_n_oe), .o_cb_clk_en(o_cb_clk_en), .o_fwd_valid(o_fwd_valid),
	.o_fwd_type0(o_fwd_type0), .o_fwd_type1(o_fwd_type1));
`default_nettype wire

// ---- test/cbs_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbs_host (
	// clock and answers
	input  wire logic        i_clk_sys,
	input  wire logic        i_ack,
	input  wire logic        i_claim,
	input  wire logic        i_pm_hit,
	input  wire logic [31:0] i_rdata,
	// request lines
	output logic             o_req,
	output logic             o_wr,
	output logic             o_func,
	output logic      [5:0]  o_dword,
	output logic      [3:0]  o_be,
	output logic      [31:0] o_wdata
);
	// idle bus
	initial begin
		{o_req, o_wr, o_func, o_dword, o_be, o_wdata} = '0;
	end
	// one configuration cycle, answer taken the cycle after
	task automatic xfer(input logic wr, input logic f, input logic [5:0] d, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output logic [2:0] rsp);
		@(posedge i_clk_sys);
		o_req   <= 1'b1;
		o_wr    <= wr;
		o_func  <= f;
		o_dword <= d;
		o_be    <= be;
		o_wdata <= wd;
		@(posedge i_clk_sys);
		o_req   <= 1'b0;
		o_dword <= ~d; // released lines stop showing old value
		o_wdata <= ~wd;
		#1;
		rd  = i_rdata;
		rsp = {i_ack, i_claim, i_pm_hit};
	endtask
endmodule // cbs_host
`default_nettype wire

// ---- test/cbs_bridge_cfg_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module cbs_bridge_cfg_bench;
	logic clk = 0, rstn = 0, fwd_req = 0, ack, claim, pm, clk_en, fv, f0, f1;
	logic [1:0] frst = 0, mdp = 0, pre = 0, cserr_n = '1, cperr_n = '1, cs_o, cs_oe;
	logic [4:0][1:0] ev = '0;
	logic [7:0] fwd_bus = 0;
	logic fwd_func = 0;
	logic [31:0] rdata, wdata;
	logic req, wr, func;
	logic [5:0] dword;
	logic [3:0] be;
	int mismatches = 0, tests_run = 0, cyc = 0;
	// clock and timeout
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			print_verdict();
		end
	end
	cbs_bridge_cfg u_cbs_bridge_cfg (.i_clk_sys(clk), .i_rstn(rstn), .i_func_rst(frst),
		.i_cfg_req(req), .i_cfg_wr(wr), .i_cfg_func(func), .i_cfg_dword(dword), .i_cfg_be(be),
		.i_cfg_wdata(wdata), .o_cfg_ack(ack), .o_cfg_claim(claim), .o_cfg_pm_hit(pm),
		.o_cfg_rdata(rdata), .i_cb_addr_par_err(ev[0]), .i_cb_data_par_err(ev[1]),
		.i_cb_master_abort(ev[2]), .i_cb_target_abort_rx(ev[3]), .i_cb_target_abort_tx(ev[4]),
		.i_cb_master_dphase(mdp), .i_parity_resp_en(pre), .i_cb_cserr_n(cserr_n),
		.i_cb_cperr_n(cperr_n), .o_cb_cserr_n_o(cs_o), .o_cb_cserr_n_oe(cs_oe),
		.o_cb_clk_en(clk_en), .i_fwd_req(fwd_req), .i_fwd_func(fwd_func), .i_fwd_bus(fwd_bus),
		.o_fwd_valid(fv), .o_fwd_type0(f0), .o_fwd_type1(f1));
	cbs_host u_cbs_host (.i_clk_sys(clk), .i_ack(ack), .i_claim(claim), .i_pm_hit(pm),
		.i_rdata(rdata), .o_req(req), .o_wr(wr), .o_func(func), .o_dword(dword), .o_be(be),
		.o_wdata(wdata));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// access and judge data and response
	task automatic acc(input logic w, input logic f, input logic [5:0] d, input logic [3:0] b,
		input logic [31:0] wd, input logic [31:0] e, input logic [2:0] r);
		logic [31:0] g;
		logic [2:0] s;
		u_cbs_host.xfer(w, f, d, b, wd, g, s);
		chk(g, e);
		chk(32'(s), 32'(r));
	endtask
	task automatic fwd(input logic fn, input logic [7:0] b, input logic [2:0] e);
		@(posedge clk);
		fwd_req  <= 1'b1;
		fwd_func <= fn;
		fwd_bus  <= b;
		@(posedge clk);
		fwd_req <= 1'b0;
		fwd_bus <= ~b;
		#1 chk(32'({fv, f0, f1}), 32'(e));
	endtask
	task automatic t_reset();
		acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0, 3'b110);
		acc(0, 1, 6'h05, 4'h0, 0, 32'h020000a0, 3'b110);
		acc(0, 0, 6'h06, 4'h0, 0, 32'h0, 3'b110);
		acc(0, 0, 6'h28, 4'h0, 0, 32'h0, 3'b101);
		acc(0, 0, 6'h29, 4'h0, 0, 32'h0, 3'b101);
		acc(0, 0, 6'h10, 4'h0, 0, 32'h0, 3'b100);
		acc(1, 0, 6'h05, 4'h1, 32'hff, 32'h0, 3'b110);
		acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0, 3'b110);
		$display("t_reset done");
	endtask
	task automatic t_events();
		int b[5] = '{15, 15, 13, 12, 11};
		for (int k = 0; k < 5; k++) begin
			@(posedge clk) ev[k][0] <= 1'b1;
			acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0 | (32'h1 << (b[k] + 16)), 3'b110);
			@(posedge clk) ev <= '0;
			acc(1, 0, 6'h05, 4'hc, 0, 32'h0, 3'b110);
			acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0 | (32'h1 << (b[k] + 16)), 3'b110);
			acc(0, 1, 6'h05, 4'h0, 0, 32'h020000a0, 3'b110);
			acc(1, 0, 6'h05, 4'hc, 32'h1 << (b[k] + 16), 32'h0, 3'b110);
			acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0, 3'b110);
		end
		$display("t_events done");
	endtask
	task automatic t_pins();
		@(posedge clk) cserr_n[0] <= 1'b0;
		repeat (5) @(posedge clk);
		acc(0, 0, 6'h05, 4'h0, 0, 32'h420000a0, 3'b110);
		acc(1, 0, 6'h05, 4'hc, 32'h40000000, 32'h0, 3'b110);
		acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0, 3'b110);
		@(posedge clk) cserr_n[0] <= 1'b1;
		for (int en = 0; en < 2; en++) begin
			@(posedge clk) {cperr_n[0], mdp[0], pre[0]} <= {2'b01, 1'(en)};
			repeat (4) @(posedge clk);
			{cperr_n[0], mdp[0], pre[0]} <= 3'b100;
			repeat (3) @(posedge clk);
			acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0 | (32'(en) << 24), 3'b110);
			acc(1, 0, 6'h05, 4'hc, 32'h01000000, 32'h0, 3'b110);
		end
		$display("t_pins done");
	endtask
	task automatic t_bus();
		@(posedge clk) ev[2][0] <= 1'b1;
		@(posedge clk) ev <= '0;
		acc(1, 0, 6'h06, 4'h7, 32'h00090305, 32'h0, 3'b110);
		acc(0, 0, 6'h06, 4'h0, 0, 32'h00090305, 3'b110);
		acc(0, 1, 6'h06, 4'h0, 0, 32'h0, 3'b110);
		fwd(0, 8'h03, 3'b110);
		fwd(0, 8'h04, 3'b101);
		fwd(0, 8'h09, 3'b101);
		fwd(0, 8'h0a, 3'b100);
		fwd(0, 8'h02, 3'b100);
		fwd(0, 8'h00, 3'b100);
		fwd(1, 8'h00, 3'b110);
		@(posedge clk) frst[0] <= 1'b1;
		@(posedge clk) frst[0] <= 1'b0;
		acc(0, 0, 6'h05, 4'h0, 0, 32'h220000a0, 3'b110);
		acc(0, 0, 6'h06, 4'h0, 0, 32'h0, 3'b110);
		@(posedge clk) rstn <= 1'b0;
		@(posedge clk) rstn <= 1'b1;
		acc(0, 0, 6'h05, 4'h0, 0, 32'h020000a0, 3'b110);
		$display("t_bus done");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_events();
		t_pins();
		t_bus();
		print_verdict();
	end
endmodule // cbs_bridge_cfg_bench
`default_nettype wire
